// ### design/bsv_top.sv
// Boot strap vector capture: samples the strap pins as the global reset
// pin is released, keeps them for readback, runs the reset-halt hold.
// Assumes strap and reset pins are asynchronous; AHB-Lite on clk.
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module bsv_top
    import bsv_pkg::*;
(
    // Clock and core reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Global reset pin and strap pins
    input  wire logic        global_reset_n,
    input  wire logic        global_clk_freq_select,
    input  wire logic [2:0]  port_clocking_strap,
    input  wire logic [3:0]  eeprom_bus_addr_strap,
    input  wire logic        master_bus_slow_strap,
    input  wire logic        merge_pair_0_1,
    input  wire logic        merge_pair_2_3,
    input  wire logic        merge_pair_4_5,
    input  wire logic        merge_pair_6_7,
    input  wire logic        merge_pair_8_9,
    input  wire logic        merge_pair_10_11,
    input  wire logic        halt_after_reset,
    input  wire logic [3:0]  target_bus_addr_strap,
    input  wire logic [3:0]  switch_operating_select,
    // AHB-Lite register port
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Register writes from the EEPROM loader
    input  wire logic        ee_wr,
    input  wire logic [7:0]  ee_addr,
    input  wire logic [31:0] ee_wdata,
    // Packets reaching the ports
    input  wire logic        pkt_valid,
    input  wire logic        pkt_cfg_type0,
    output logic             pkt_retry,
    output logic             pkt_discard,
    output logic             pkt_accept,
    // Configuration seen by the rest of the switch
    output logic             refclk_freq_sel,
    output logic      [2:0]  port_clocking_mode,
    output logic      [3:0]  eeprom_bus_addr,
    output logic      [15:0] master_bus_prescaler,
    output logic      [5:0]  merge_pairs,
    output logic      [3:0]  target_bus_addr,
    output logic      [3:0]  switch_mode,
    output logic             device_in_reset,
    output logic             buses_active
);

    // Pin side, after synchronising
    logic [BSV_VEC_W-1:0] raw_vec;
    logic [BSV_VEC_W-1:0] pin_vec;
    logic                 rst_pin;
    logic                 rst_prev_ff;
    logic                 release_ev;

    // Captured vector and working copies
    logic [BSV_VEC_W-1:0]  cap_ff, nxt_cap;
    logic [2:0]            pclk_ff, nxt_pclk;
    logic [BSV_PRES_W-1:0] pres_ff, nxt_pres;
    logic                  halt_ff, nxt_halt;
    bsv_state_t            st_ff, nxt_st;

    // Register access
    logic        bus_wr;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata;
    logic        wr_any;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [31:0] rdata;

    // Packet answers and buses-active flag
    logic retry_ff, nxt_retry;
    logic disc_ff, nxt_disc;
    logic acc_ff, nxt_acc;
    logic bus_act_ff, nxt_bus_act;
    logic in_rst_ff, nxt_in_rst;

    // Strap pins assembled in status-word order
    assign raw_vec = {switch_operating_select, target_bus_addr_strap,
                      halt_after_reset, merge_pair_10_11, merge_pair_8_9,
                      merge_pair_6_7, merge_pair_4_5, merge_pair_2_3,
                      merge_pair_0_1, master_bus_slow_strap,
                      eeprom_bus_addr_strap, port_clocking_strap,
                      global_clk_freq_select};

    // Straps and reset share one synchroniser so they stay aligned
    bsv_sync #(.W(BSV_VEC_W + 1)) u_sync (
        .clk     (clk),
        .srst    (srst),
        .pin_in  ({global_reset_n, raw_vec}),
        .pin_out ({rst_pin, pin_vec})
    );

    bsv_ahb u_ahb (
        .clk       (clk),
        .srst      (srst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .reg_wr    (bus_wr),
        .reg_addr  (bus_addr),
        .reg_wdata (bus_wdata),
        .reg_rdata (rdata)
    );

    // Release of the global reset pin, seen once per fundamental reset
    assign release_ev = rst_pin && !rst_prev_ff;

    // Bus write wins over the EEPROM loader in the same cycle
    always_comb
    begin
        wr_any  = bus_wr || ee_wr;
        wr_addr = bus_wr ? bus_addr : ee_addr;
        wr_data = bus_wr ? bus_wdata : ee_wdata;
    end

    // Capture and working configuration
    always_comb
    begin
        nxt_cap  = cap_ff;
        nxt_pclk = pclk_ff;
        nxt_pres = pres_ff;
        nxt_halt = halt_ff;
        if (release_ev)
        begin
            // Pins are copied only here; any other time they do nothing
            nxt_cap  = pin_vec;
            nxt_pclk = pin_vec[BSV_ST_PCLK +: 3];
            nxt_pres = pin_vec[BSV_ST_SLOW] ? BSV_PRES_SLOW
                                            : BSV_PRES_FAST;
            nxt_halt = pin_vec[BSV_ST_HALT];
        end
        else if (wr_any && st_ff != BSV_IN_RESET)
        begin
            // Status word and fixed straps have no write path at all
            unique case (wr_addr)
                BSV_OFS_PCLK:   nxt_pclk = wr_data[2:0];
                BSV_OFS_BUSCTL: nxt_pres = wr_data[15:0];
                BSV_OFS_SWITCH_CONTROL:  nxt_halt = wr_data[BSV_SC_HALT];
                default:        nxt_halt = halt_ff;
            endcase
        end
    end

    // Sequence: hold in reset while the pin is low, then halt or run
    always_comb
    begin
        nxt_st = st_ff;
        if (!rst_pin)
            nxt_st = BSV_IN_RESET;
        else
        begin
            unique case (st_ff)
                BSV_IN_RESET:
                    if (release_ev)
                        nxt_st = pin_vec[BSV_ST_HALT] ? BSV_HALTED
                                                      : BSV_RUNNING;
                BSV_HALTED:
                    if (!halt_ff)
                        nxt_st = BSV_RUNNING;
                BSV_RUNNING:
                    nxt_st = BSV_RUNNING;
                default:
                    nxt_st = BSV_IN_RESET;
            endcase
        end
    end

    // Packet answers: retry or discard until normal operation begins
    always_comb
    begin
        nxt_retry   = 1'b0;
        nxt_disc    = 1'b0;
        nxt_acc     = 1'b0;
        nxt_bus_act = (nxt_st != BSV_IN_RESET);
        nxt_in_rst  = (nxt_st != BSV_RUNNING);
        if (pkt_valid)
        begin
            if (st_ff == BSV_RUNNING)
                nxt_acc = 1'b1;
            else if (st_ff == BSV_HALTED && pkt_cfg_type0)
                nxt_retry = 1'b1;
            else
                nxt_disc = 1'b1;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        rdata = 32'h00000000;
        unique case (bus_addr)
            BSV_OFS_STATUS: rdata[BSV_VEC_W-1:0] = cap_ff;
            BSV_OFS_PCLK:   rdata[2:0] = pclk_ff;
            BSV_OFS_BUSCTL: rdata[BSV_PRES_W-1:0] = pres_ff;
            BSV_OFS_SWITCH_CONTROL:
            begin
                rdata[BSV_SC_HALT]       = halt_ff;
                rdata[BSV_SC_UNLOCK]     = (st_ff != BSV_RUNNING);
                rdata[BSV_SC_STATE +: 2] = st_ff;
            end
            default:        rdata = 32'h00000000;
        endcase
    end

    // State registers only
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rst_prev_ff <= BSV_RST_PIN;
            cap_ff      <= BSV_RST_VEC;
            pclk_ff     <= BSV_RST_PCLK;
            pres_ff     <= BSV_PRES_FAST;
            halt_ff     <= 1'b0;
            st_ff       <= BSV_IN_RESET;
            retry_ff    <= 1'b0;
            disc_ff     <= 1'b0;
            acc_ff      <= 1'b0;
            bus_act_ff  <= 1'b0;
            in_rst_ff   <= 1'b1;
        end
        else
        begin
            rst_prev_ff <= rst_pin;
            cap_ff      <= nxt_cap;
            pclk_ff     <= nxt_pclk;
            pres_ff     <= nxt_pres;
            halt_ff     <= nxt_halt;
            st_ff       <= nxt_st;
            retry_ff    <= nxt_retry;
            disc_ff     <= nxt_disc;
            acc_ff      <= nxt_acc;
            bus_act_ff  <= nxt_bus_act;
            in_rst_ff   <= nxt_in_rst;
        end
    end

    // Fixed straps drive straight from the captured copy
    assign refclk_freq_sel      = cap_ff[BSV_ST_GCLK];
    assign eeprom_bus_addr      = cap_ff[BSV_ST_EEADR +: 4];
    assign merge_pairs          = cap_ff[BSV_ST_MERGE +: 6];
    assign target_bus_addr      = cap_ff[BSV_ST_TGADR +: 4];
    assign switch_mode          = cap_ff[BSV_ST_MODE +: 4];
    assign port_clocking_mode   = pclk_ff;
    assign master_bus_prescaler = pres_ff;
    assign device_in_reset      = in_rst_ff;
    assign buses_active         = bus_act_ff;
    assign pkt_retry            = retry_ff;
    assign pkt_discard          = disc_ff;
    assign pkt_accept           = acc_ff;

    // Pin changes away from the release edge leave the capture alone
    chk_straps_ignored: assert property (
        @(posedge clk) disable iff (srst)
        !release_ev |=> $stable(cap_ff))
        else $error("strap capture changed without a reset release");

    // Release edge copies the filtered pins exactly
    chk_capture_edge: assert property (
        @(posedge clk) disable iff (srst)
        release_ev |=> cap_ff == $past(pin_vec))
        else $error("captured vector differs from pins at release");

    // A status read returns the vector as it stood in its wait cycle
    chk_status_read: assert property (
        @(posedge clk) disable iff (srst)
        bus_addr == BSV_OFS_STATUS && !hreadyout
        |=> hrdata[BSV_VEC_W-1:0] == $past(cap_ff))
        else $error("status read does not match capture");

    // Port clocking working copy starts from the strap
    chk_pclk_load: assert property (
        @(posedge clk) disable iff (srst)
        release_ev |=> pclk_ff == cap_ff[BSV_ST_PCLK +: 3])
        else $error("port clocking not loaded from strap");

    // Prescaler follows the slow-mode strap at capture
    chk_pres_load: assert property (
        @(posedge clk) disable iff (srst)
        release_ev |=> pres_ff == (cap_ff[BSV_ST_SLOW] ? BSV_PRES_SLOW
                                                       : BSV_PRES_FAST))
        else $error("prescaler not chosen by slow strap");

    // Halt strap sends the sequence to the halted state
    chk_halt_entry: assert property (
        @(posedge clk) disable iff (srst)
        release_ev && pin_vec[BSV_ST_HALT] && rst_pin
        |=> st_ff == BSV_HALTED ##1 buses_active)
        else $error("halt strap did not hold device with buses up");

    // A set halt bit keeps the halted state from moving on to run
    chk_halt_exit: assert property (
        @(posedge clk) disable iff (srst)
        st_ff == BSV_HALTED && halt_ff |=> st_ff != BSV_RUNNING)
        else $error("left halted state with halt bit set");

    // Halted type 0 config request answered with retry next cycle
    chk_halt_retry: assert property (
        @(posedge clk) disable iff (srst)
        st_ff == BSV_HALTED && pkt_valid && pkt_cfg_type0
        |=> pkt_retry && !pkt_accept)
        else $error("halted config request not retried");

    // Halted non-config packet dropped
    chk_halt_drop: assert property (
        @(posedge clk) disable iff (srst)
        st_ff == BSV_HALTED && pkt_valid && !pkt_cfg_type0
        |=> pkt_discard && !pkt_retry)
        else $error("halted packet not discarded");

    // Fixed straps never move between fundamental resets
    chk_fixed_hold: assert property (
        @(posedge clk) disable iff (srst)
        st_ff != BSV_IN_RESET && rst_pin |=> $stable(switch_mode)
        && $stable(target_bus_addr) && $stable(merge_pairs)
        && $stable(eeprom_bus_addr) && $stable(refclk_freq_sel))
        else $error("fixed strap output changed");

    // A working write leaves the status copy untouched
    chk_override_only: assert property (
        @(posedge clk) disable iff (srst)
        wr_any && !release_ev && wr_addr == BSV_OFS_PCLK
        && st_ff != BSV_IN_RESET |=> $stable(cap_ff)
        && pclk_ff == $past(wr_data[2:0]))
        else $error("override write reached status copy");

endmodule
`default_nettype wire

// ### design/bsv_pkg.sv
// Package for the boot strap vector capture block.
// Assumes one 100 MHz core clock and a byte-addressed register bus with word-aligned registers.
package bsv_pkg;

    // Register byte offsets
    localparam logic [7:0] BSV_OFS_STATUS   = 8'h00;
    localparam logic [7:0] BSV_OFS_PCLK     = 8'h04;
    localparam logic [7:0] BSV_OFS_BUSCTL   = 8'h08;
    localparam logic [7:0] BSV_OFS_SWITCH_CONTROL    = 8'h0c;

    // Field positions in the boot strap status word
    localparam int BSV_ST_GCLK  = 0;
    localparam int BSV_ST_PCLK  = 1;
    localparam int BSV_ST_EEADR = 4;
    localparam int BSV_ST_SLOW  = 8;
    localparam int BSV_ST_MERGE = 9;
    localparam int BSV_ST_HALT  = 15;
    localparam int BSV_ST_TGADR = 16;
    localparam int BSV_ST_MODE  = 20;

    // Field positions in the switch control word
    localparam int BSV_SC_HALT   = 0;
    localparam int BSV_SC_UNLOCK = 1;
    localparam int BSV_SC_STATE  = 2;

    // Width of the whole strap vector and the prescaler field
    localparam int BSV_VEC_W  = 24;
    localparam int BSV_PRES_W = 16;

    // Prescaler values chosen by the slow-mode strap
    localparam logic [15:0] BSV_PRES_FAST = 16'h00fa;
    localparam logic [15:0] BSV_PRES_SLOW = 16'h03e8;

    // Values after reset
    localparam logic [23:0] BSV_RST_VEC  = 24'h000000;
    localparam logic [2:0]  BSV_RST_PCLK = 3'h0;
    localparam logic        BSV_RST_PIN  = 1'b0;

    // Fundamental reset sequence, Gray coded along reset-halt-run
    typedef enum logic [1:0] {
        BSV_IN_RESET = 2'b00,
        BSV_HALTED   = 2'b01,
        BSV_RUNNING  = 2'b11
    } bsv_state_t;

endpackage

// ### design/bsv_sync.sv
// Three-flop input synchroniser with agreement filter, one lane per bit.
// Assumes the inputs are asynchronous pins; output is registered.
`timescale 1ns/100ps
`default_nettype none
module bsv_sync
    import bsv_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Raw pins and filtered result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    // Output moves only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_comb
            begin
                nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
            end
        end
    endgenerate

    // First stage is read only by the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            out_ff <= '0;
        end
        else
        begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign pin_out = out_ff;

endmodule
`default_nettype wire

// ### design/bsv_ahb.sv
// AHB-Lite slave front end: one wait state on every transfer.
// Assumes a single master, whole-word single transfers only.
`timescale 1ns/100ps
`default_nettype none
module bsv_ahb
    import bsv_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // AHB-Lite slave side
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Register side
    output logic             reg_wr,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata
);

    logic       pend_ff, nxt_pend;
    logic       wr_ff, nxt_wr;
    logic [7:0] addr_ff, nxt_addr;
    logic       rdy_ff, nxt_rdy;
    logic [31:0] rd_ff, nxt_rd;
    logic       take;

    // Size is ignored: only whole words are ever issued
    assign take = hsel && htrans[1] && hready;

    // Address phase captured; data phase held one cycle by a wait state
    always_comb
    begin
        nxt_pend = take;
        nxt_wr   = take ? hwrite : wr_ff;
        nxt_addr = take ? {haddr[7:2], 2'b00} : addr_ff;
        nxt_rdy  = !take;
        nxt_rd   = pend_ff ? reg_rdata : rd_ff;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pend_ff <= 1'b0;
            wr_ff   <= 1'b0;
            addr_ff <= 8'h00;
            rdy_ff  <= 1'b1;
            rd_ff   <= 32'h00000000;
        end
        else
        begin
            pend_ff <= nxt_pend;
            wr_ff   <= nxt_wr;
            addr_ff <= nxt_addr;
            rdy_ff  <= nxt_rdy;
            rd_ff   <= nxt_rd;
        end
    end

    // Write lands in the wait cycle, while hwdata stands
    assign reg_wr    = pend_ff && wr_ff;
    assign reg_addr  = addr_ff;
    assign reg_wdata = hwdata;
    assign hreadyout = rdy_ff;
    assign hrdata    = rd_ff;
    assign hresp     = 1'b0;

endmodule
`default_nettype wire

// ### verification/bsv_strap_board.sv
// Board model: the strap pins seen by the capture block.
// Assumes the bench raises hold across the release of the global reset.
`timescale 1ns/100ps
`default_nettype none
module bsv_strap_board
(
    // Control from the bench
    input  wire logic        hold,
    input  wire logic [23:0] vec,
    // Strap pins, packed in status-word order
    output logic      [23:0] pins
);
    // Straps are steady through the release window; afterwards they swing
    // to the inverse, so anything sampled late shows up at once
    assign pins = hold ? vec : ~vec;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the boot strap vector capture block.
// Assumes one 100 MHz clock; registers reached over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bsv_pkg::*;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        global_reset_n = 1'b1;
    logic        hold = 1'b1;
    logic [23:0] vec = 24'h000000;
    logic [23:0] pins;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        ee_wr = 1'b0;
    logic [7:0]  ee_addr = 8'h00;
    logic [31:0] ee_wdata = 32'h0;
    logic        pkt_valid = 1'b0;
    logic        pkt_cfg_type0 = 1'b0;
    logic        pkt_retry, pkt_discard, pkt_accept, refclk_freq_sel;
    logic [2:0]  port_clocking_mode;
    logic [3:0]  eeprom_bus_addr, target_bus_addr, switch_mode;
    logic [15:0] master_bus_prescaler;
    logic [5:0]  merge_pairs;
    logic        device_in_reset, buses_active;
    logic [31:0] rd;
    int          fail_count = 0;
    int          comparisons = 0;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #5 clk = ~clk;

    bsv_strap_board i_board (.hold(hold), .vec(vec), .pins(pins));

    bsv_top i_dut (
        .clk(clk), .srst(srst), .global_reset_n(global_reset_n),
        .global_clk_freq_select(pins[0]), .port_clocking_strap(pins[3:1]),
        .eeprom_bus_addr_strap(pins[7:4]), .master_bus_slow_strap(pins[8]),
        .merge_pair_0_1(pins[9]), .merge_pair_2_3(pins[10]),
        .merge_pair_4_5(pins[11]), .merge_pair_6_7(pins[12]),
        .merge_pair_8_9(pins[13]), .merge_pair_10_11(pins[14]),
        .halt_after_reset(pins[15]), .target_bus_addr_strap(pins[19:16]),
        .switch_operating_select(pins[23:20]),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .pkt_valid(pkt_valid), .pkt_cfg_type0(pkt_cfg_type0),
        .pkt_retry(pkt_retry), .pkt_discard(pkt_discard),
        .pkt_accept(pkt_accept), .refclk_freq_sel(refclk_freq_sel),
        .port_clocking_mode(port_clocking_mode),
        .eeprom_bus_addr(eeprom_bus_addr),
        .master_bus_prescaler(master_bus_prescaler),
        .merge_pairs(merge_pairs), .target_bus_addr(target_bus_addr),
        .switch_mode(switch_mode), .device_in_reset(device_in_reset),
        .buses_active(buses_active)
    );

    // Closing report, shared by the main sequence and every timeout
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One AHB-Lite single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 99);
        r = hrdata;
        check("response", 32'(hresp), 32'h0);
        if (n >= 99)
        begin
            fail_count++;
            print_verdict();
        end
    endtask

    // One packet; the answer pulse stands for the cycle after it is taken
    task automatic pkt(input logic t0, input logic [2:0] exp);
        logic [2:0] ans;
        pkt_valid <= 1'b1;
        pkt_cfg_type0 <= t0;
        @(posedge clk);
        pkt_valid <= 1'b0;
        @(negedge clk);
        ans = {pkt_retry, pkt_discard, pkt_accept};
        check("packet answer", 32'(ans), 32'(exp));
        @(posedge clk);
    endtask

    // Fundamental reset with the given straps, then wait for release
    task automatic frst(input logic [23:0] v);
        int n;
        vec <= v;
        hold <= 1'b1;
        global_reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        global_reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        hold <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (buses_active !== 1'b1 && n < 50);
        @(posedge clk);
        // A release that never brings the buses up ends the run
        if (n >= 50)
        begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic caps(input logic [23:0] v);
        xfer(1'b0, BSV_OFS_STATUS, 32'h0, rd);
        check("status", rd, {8'h00, v});
        check("refclk", 32'(refclk_freq_sel), 32'(v[0]));
        check("clk mode", 32'(port_clocking_mode), 32'(v[3:1]));
        check("ee addr", 32'(eeprom_bus_addr), 32'(v[7:4]));
        check("prescaler", 32'(master_bus_prescaler),
              32'(v[8] ? BSV_PRES_SLOW : BSV_PRES_FAST));
        check("merges", 32'(merge_pairs), 32'(v[14:9]));
        check("tgt addr", 32'(target_bus_addr), 32'(v[19:16]));
        check("sw mode", 32'(switch_mode), 32'(v[23:20]));
    endtask

    // Watchdog so that no hang outlives the run budget
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // Main sequence: halted boot, overrides, release, then a plain boot
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        frst(24'ha5d56b);
        caps(24'ha5d56b);
        check("in reset", 32'(device_in_reset), 32'h1);
        check("buses", 32'(buses_active), 32'h1);
        xfer(1'b0, BSV_OFS_SWITCH_CONTROL, 32'h0, rd);
        check("switch_control halted", rd, 32'h7);
        pkt(1'b1, 3'b100);
        pkt(1'b0, 3'b010);
        xfer(1'b1, BSV_OFS_PCLK, 32'h2, rd);
        check("clk override", 32'(port_clocking_mode), 32'h2);
        xfer(1'b1, BSV_OFS_BUSCTL, 32'h1234, rd);
        check("pres override", 32'(master_bus_prescaler), 32'h1234);
        xfer(1'b1, BSV_OFS_STATUS, 32'h0, rd);
        ee_wr <= 1'b1;
        ee_addr <= BSV_OFS_PCLK;
        ee_wdata <= 32'h6;
        @(posedge clk);
        ee_wr <= 1'b0;
        @(posedge clk);
        check("ee write", 32'(port_clocking_mode), 32'h6);
        // Straps now swing; captured status must not follow them
        xfer(1'b0, BSV_OFS_STATUS, 32'h0, rd);
        check("status kept", rd, 32'h00a5d56b);
        xfer(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        xfer(1'b1, BSV_OFS_SWITCH_CONTROL, 32'h0, rd);
        @(posedge clk);
        check("released", 32'(device_in_reset), 32'h0);
        xfer(1'b0, BSV_OFS_SWITCH_CONTROL, 32'h0, rd);
        check("switch_control running", rd, 32'hc);
        pkt(1'b1, 3'b001);
        frst(24'h5a2a94);
        caps(24'h5a2a94);
        check("no halt", 32'(device_in_reset), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
